/* design/video_plane_consts.vh */
`ifndef VIDEO_PLANE_CONSTS_VH
`define VIDEO_PLANE_CONSTS_VH
// ==========================================================
// Port addresses
`define PORT_PLANE_CTRL    8'hD8
`define PORT_MIRROR_LATCH  8'hDA
`define PORT_CTRL_INDEX    8'hDC
`define PORT_CTRL_DATA     8'hDD
// ==========================================================
// Plane windows (address bits 23:16)
`define PAGE_BLUE          8'h0C
`define PAGE_RED           8'h0D
`define PAGE_GREEN         8'h0E
// ==========================================================
// Control register fields
`define BIT_MEM_DISABLE    7
`define BIT_REPL_BLUE      6
`define BIT_REPL_GREEN     5
`define BIT_REPL_RED       4
`define BIT_SOLID_N        3
`define BIT_EN_BLUE        2
`define BIT_EN_GREEN       1
`define BIT_EN_RED         0
// ==========================================================
// Reset values and indexes
`define RST_PLANE_CTRL     8'h08
`define RST_ZERO           8'h00
`define IDX_START_HIGH     5'h0C
`define IDX_START_LOW      5'h0D
`define IDX_COUNT          5'h12
`define START_HIGH_MASK    8'h3F
`endif

/* design/ctrl_reg_file.v */
`timescale 1ns/1ps
`include "video_plane_consts.vh"
// ==========================================================
// Display controller register file, 18 bytes, registered read
module ctrl_reg_file #(
  parameter DEPTH = 18
) (
  input  wire       clock,   // System clock
  input  wire [4:0] addr,    // Register index
  input  wire       wr_en,   // Write strobe
  input  wire [7:0] wr_data, // Write data
  output reg  [7:0] rd_data  // Registered read data
);
  reg [7:0] mem_q [0:DEPTH-1];

  // Write, masking the two unused start-high bits
  always @(posedge clock) begin
    if (wr_en && (addr < DEPTH)) begin
      if (addr == `IDX_START_HIGH)
        mem_q[addr] <= wr_data & `START_HIGH_MASK;
      else
        mem_q[addr] <= wr_data;
    end
  end

  // Registered read
  always @(posedge clock) begin
    if (addr < DEPTH)
      rd_data <= mem_q[addr];
    else
      rd_data <= `RST_ZERO;
  end
endmodule

/* design/video_plane_control.v */
`timescale 1ns/1ps
`include "video_plane_consts.vh"
// Functional notes
// - Control register decoded at video_plane_control
// - Upper nibble access, lower nibble display
// - Every control bit except bit 7 active low
// - Blue 0C, red 0D, green 0E pages
// - Bit 7 one blocks all plane access
// - Bit 6 zero replicates writes into blue
// - Bits 5,4 replicate into green, red
// - Reads return only addressed plane
// - Addressed plane written unless bit 7 one
// - Bit 3 zero forces solid colour
// - Bit 3 one passes enabled planes
// - All planes disabled gives black
// - Display gating never alters memory
// - Value 08 is normal white-text mode
// - Index port DC, data port DD
// - Start address 14 bits, high/low
// - Byte MSB shifts out first
module video_plane_control (
  input  wire        clock,        // 25 MHz system clock
  input  wire        rst_n,        // Async reset, active low
  // Host I/O port bus
  input  wire [7:0]  io_addr,      // Port address
  input  wire        io_rd,        // Port read strobe
  input  wire        io_wr,        // Port write strobe
  input  wire [7:0]  io_wdata,     // Port write data
  output reg  [7:0]  io_rdata_q,   // Port read data
  output reg         io_rvalid_q,  // Read data valid pulse
  // Host memory bus
  input  wire [23:0] mem_addr,     // Host memory address
  input  wire        mem_rd,       // Memory read strobe
  input  wire        mem_wr,       // Memory write strobe
  input  wire [7:0]  mem_wdata,    // Memory write data
  output wire        mem_hit,      // Access claimed by a plane
  // Video memory plane ports
  output wire [15:0] plane_addr,   // Offset within plane
  output wire [7:0]  plane_wdata,  // Data to planes
  output wire [2:0]  plane_we,     // Write enables {blue,green,red}
  output wire [2:0]  plane_re,     // Read enables {blue,green,red}
  // Pixel path
  input  wire        byte_load,    // Load new bytes into shifters
  input  wire [7:0]  pix_blue,     // Blue plane byte
  input  wire [7:0]  pix_green,    // Green plane byte
  input  wire [7:0]  pix_red,      // Red plane byte
  output reg  [2:0]  pixel_rgb_q,  // Output pixel {red,green,blue}
  // Mirror and start address
  output reg  [7:0]  mirror_latch_q, // Start address mirror latch
  output wire [13:0] display_start   // Start address
);
  // ==========================================================
  // Control and pointer registers
  reg  [7:0] plane_ctrl_q;
  reg  [4:0] controller_index_pointer_q;
  reg  [7:0] start_high_q;
  reg  [7:0] start_low_q;
  wire [7:0] reg_rdata;

  wire wr_ctrl  = io_wr && (io_addr == `PORT_PLANE_CTRL);
  wire wr_latch = io_wr && (io_addr == `PORT_MIRROR_LATCH);
  wire wr_index = io_wr && (io_addr == `PORT_CTRL_INDEX);
  wire wr_data  = io_wr && (io_addr == `PORT_CTRL_DATA);

  // Port writes
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      plane_ctrl_q              <= `RST_PLANE_CTRL;
      mirror_latch_q            <= `RST_ZERO;
      controller_index_pointer_q <= 5'h00;
      start_high_q              <= `RST_ZERO;
      start_low_q               <= `RST_ZERO;
    end else begin
      if (wr_ctrl)
        plane_ctrl_q <= io_wdata;
      if (wr_latch)
        mirror_latch_q <= io_wdata;
      if (wr_index)
        controller_index_pointer_q <= io_wdata[4:0];
      if (wr_data && controller_index_pointer_q == `IDX_START_HIGH)
        start_high_q <= io_wdata & `START_HIGH_MASK;
      if (wr_data && controller_index_pointer_q == `IDX_START_LOW)
        start_low_q <= io_wdata;
    end
  end

  assign display_start = {start_high_q[5:0], start_low_q};

  // Controller register storage
  ctrl_reg_file #(
    .DEPTH (18)
  ) u_regs (
    .clock   (clock),
    .addr    (controller_index_pointer_q),
    .wr_en   (wr_data),
    .wr_data (io_wdata),
    .rd_data (reg_rdata)
  );

  // ==========================================================
  // Port reads; every port, data port included, answers two cycles after the read strobe
  reg       rd_pend_q;
  reg [7:0] rd_port_q;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_pend_q   <= 1'b0;
      rd_port_q   <= `RST_ZERO;
      io_rdata_q  <= `RST_ZERO;
      io_rvalid_q <= 1'b0;
    end else begin
      rd_pend_q   <= io_rd;
      rd_port_q   <= io_addr;
      io_rvalid_q <= rd_pend_q;
      if (rd_pend_q) begin
        case (rd_port_q)
          `PORT_PLANE_CTRL:   io_rdata_q <= plane_ctrl_q;
          `PORT_MIRROR_LATCH: io_rdata_q <= mirror_latch_q;
          `PORT_CTRL_INDEX:   io_rdata_q <= {3'b000, controller_index_pointer_q};
          `PORT_CTRL_DATA:    io_rdata_q <= reg_rdata;
          default:            io_rdata_q <= `RST_ZERO;
        endcase
      end
    end
  end

  // ==========================================================
  // Host memory access, upper nibble only
  wire mem_on   = ~plane_ctrl_q[`BIT_MEM_DISABLE];
  wire hit_blue  = (mem_addr[23:16] == `PAGE_BLUE);
  wire hit_red   = (mem_addr[23:16] == `PAGE_RED);
  wire hit_green = (mem_addr[23:16] == `PAGE_GREEN);
  wire any_hit   = hit_blue | hit_green | hit_red;

  assign mem_hit     = any_hit & mem_on;
  assign plane_addr  = mem_addr[15:0];
  assign plane_wdata = mem_wdata;
  // Addressed plane written unless bit 7 set, others by replication
  assign plane_we[2] = mem_wr & mem_on & (hit_blue |
                       (any_hit & ~plane_ctrl_q[`BIT_REPL_BLUE]));
  assign plane_we[1] = mem_wr & mem_on & (hit_green |
                       (any_hit & ~plane_ctrl_q[`BIT_REPL_GREEN]));
  assign plane_we[0] = mem_wr & mem_on & (hit_red |
                       (any_hit & ~plane_ctrl_q[`BIT_REPL_RED]));
  // Reads ignore replication bits
  assign plane_re = {3{mem_rd & mem_on}} & {hit_blue, hit_green, hit_red};

  // ==========================================================
  // Pixel path, lower nibble only; memory never written here
  reg  [7:0] sh_blue_q;
  reg  [7:0] sh_green_q;
  reg  [7:0] sh_red_q;
  wire       solid    = ~plane_ctrl_q[`BIT_SOLID_N];
  wire       en_blue  = ~plane_ctrl_q[`BIT_EN_BLUE];
  wire       en_green = ~plane_ctrl_q[`BIT_EN_GREEN];
  wire       en_red   = ~plane_ctrl_q[`BIT_EN_RED];

  // Shifters emit the most significant bit first
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sh_blue_q  <= `RST_ZERO;
      sh_green_q <= `RST_ZERO;
      sh_red_q   <= `RST_ZERO;
    end else if (byte_load) begin
      sh_blue_q  <= pix_blue;
      sh_green_q <= pix_green;
      sh_red_q   <= pix_red;
    end else begin
      sh_blue_q  <= {sh_blue_q[6:0], 1'b0};
      sh_green_q <= {sh_green_q[6:0], 1'b0};
      sh_red_q   <= {sh_red_q[6:0], 1'b0};
    end
  end

  // Colour gating; disabled planes never light
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pixel_rgb_q <= 3'b000;
    end else if (solid) begin
      pixel_rgb_q <= {en_red, en_green, en_blue};
    end else begin
      pixel_rgb_q <= {en_red & sh_red_q[7], en_green & sh_green_q[7],
                      en_blue & sh_blue_q[7]};
    end
  end
endmodule

/* tb/video_plane_control_asserts.sv */
`timescale 1ns/1ps
// ==========
// Port checks
module video_plane_checks (
  input wire        clock,         // Clock
  input wire        rst_n,         // Reset
  input wire [7:0]  io_addr,       // Port
  input wire        io_rd,         // Read
  input wire        io_wr,         // Write
  input wire        io_rvalid_q,   // Valid
  input wire [23:0] mem_addr,      // Address
  input wire        mem_rd,        // Read
  input wire        mem_wr,        // Write
  input wire        mem_hit,       // Hit
  input wire [7:0]  mem_wdata,     // Host data
  input wire [7:0]  plane_wdata,   // Plane data
  input wire [15:0] plane_addr,    // Offset
  input wire [2:0]  plane_we,      // Writes
  input wire [2:0]  plane_re,      // Reads
  input wire [13:0] display_start  // Start
);
  // Plane owning the address
  wire [7:0] pg  = mem_addr[23:16];
  wire [2:0] own = {pg == 8'h0C, pg == 8'h0E, pg == 8'h0D};
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_blocked_idle: assert property (!mem_hit |-> plane_we == 3'h0 && plane_re == 3'h0)
    else $error("plane enable without hit");
  a_read_one: assert property (mem_rd && !mem_wr && mem_hit |-> plane_re == own)
    else $error("read not single plane");
  a_offset_pass: assert property (mem_hit |-> plane_addr == mem_addr[15:0])
    else $error("plane offset wrong");
  a_page_window: assert property (mem_hit |-> own != 3'h0)
    else $error("hit outside planes");
  a_own_write: assert property (mem_wr && mem_hit |-> (plane_we & own) == own)
    else $error("addressed plane not written");
  a_wdata_pass: assert property (mem_wr && mem_hit |-> plane_wdata == mem_wdata)
    else $error("plane write data wrong");
  a_read_latency: assert property (io_rd |-> ##2 io_rvalid_q)
    else $error("read answer late");
  a_read_cause: assert property (io_rvalid_q |-> $past(io_rd, 2))
    else $error("answer without read");
  a_start_write: assert property (!$stable(display_start) |-> $past(io_wr) && $past(io_addr) == 8'hDD)
    else $error("start changed without write");
endmodule

bind video_plane_control video_plane_checks u_checks (.clock, .rst_n, .io_addr, .io_rd,
  .io_wr, .io_rvalid_q, .mem_addr, .mem_rd, .mem_wr, .mem_hit, .mem_wdata, .plane_wdata,
  .plane_addr, .plane_we,
  .plane_re, .display_start);

/* tb/host_port_model.sv */
`timescale 1ns/1ps
// ==========
// Host port model
module host_port_model (
  input  wire       clock,        // Clock
  input  wire [7:0] io_rdata_q,   // Read data
  input  wire       io_rvalid_q,  // Read valid
  output reg  [7:0] io_addr,      // Port
  output reg        io_rd,        // Read
  output reg        io_wr,        // Write
  output reg  [7:0] io_wdata      // Data
);
  // Idle bus
  initial begin
    io_addr = 8'h00;
    io_rd = 1'b0;
    io_wr = 1'b0;
    io_wdata = 8'h00;
  end
  // Write pulse, gap before next access
  task io_write(input [7:0] a, input [7:0] d);
    begin
      @(negedge clock);
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      @(negedge clock);
      io_wr = 1'b0;
      io_wdata = ~d;
      @(negedge clock);
    end
  endtask
  // Read pulse, bounded wait for answer
  task io_read(input [7:0] a, output [7:0] d);
    integer n;
    begin
      @(negedge clock);
      io_addr = a;
      io_rd = 1'b1;
      @(negedge clock);
      io_rd = 1'b0;
      n = 0;
      while (io_rvalid_q !== 1'b1 && n < 8) begin
        @(negedge clock);
        n = n + 1;
      end
      d = io_rdata_q;
    end
  endtask
endmodule

/* tb/video_plane_control_bench.sv */
`timescale 1ns/1ps
// ==========
// Bench top
module video_plane_control_bench;
  reg         clock, rst_n, mem_rd, mem_wr, byte_load;
  reg  [23:0] mem_addr;
  reg  [7:0]  rd, e;
  wire [7:0]  io_addr, io_wdata, io_rdata_q, mirror_latch_q;
  wire        io_rd, io_wr, io_rvalid_q, mem_hit;
  wire [2:0]  plane_we, plane_re, pixel_rgb_q;
  wire [13:0] display_start;
  integer     err_total, comparisons, cyc, i;
  video_plane_control u_video_plane_control (.clock, .rst_n, .io_addr, .io_rd, .io_wr,
    .io_wdata, .io_rdata_q, .io_rvalid_q, .mem_addr, .mem_rd, .mem_wr, .mem_wdata(8'h5D),
    .mem_hit, .plane_addr(), .plane_wdata(), .plane_we, .plane_re, .byte_load,
    .pix_blue(8'h80), .pix_green(8'h01), .pix_red(8'hC0), .pixel_rgb_q, .mirror_latch_q,
    .display_start);
  host_port_model u_host (.clock, .io_rdata_q, .io_rvalid_q, .io_addr, .io_rd, .io_wr,
    .io_wdata);
  // Byte compare
  task check(input [7:0] got, input [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task end_sim;
    begin
      $display("errors=%0d comparisons=%0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  // Memory access under a control value
  task mem_chk(input [7:0] c, input [23:0] a, input w, input [2:0] we, input [2:0] re);
    begin
      u_host.io_write(8'hD8, c);
      mem_addr = a;
      mem_wr = w;
      mem_rd = !w;
      #1;
      check({5'h0, plane_we}, {5'h0, we});
      check({5'h0, plane_re}, {5'h0, re});
      check({7'h0, mem_hit}, {7'h0, ~c[7] & (a[23:16] >= 8'h0C) & (a[23:16] <= 8'h0E)});
      @(negedge clock);
      mem_wr = 1'b0;
      mem_rd = 1'b0;
    end
  endtask
  // First and last pixel of a loaded byte
  task pix_chk(input [7:0] c, input [2:0] f, input [2:0] l);
    begin
      u_host.io_write(8'hD8, c);
      byte_load = 1'b1;
      @(negedge clock);
      byte_load = 1'b0;
      @(negedge clock);
      check({5'h0, pixel_rgb_q}, {5'h0, f});
      repeat (7) @(negedge clock);
      check({5'h0, pixel_rgb_q}, {5'h0, l});
    end
  endtask
  task t_regs;
    begin
      u_host.io_read(8'hD8, rd);
      check(rd, 8'h08);
      u_host.io_write(8'hD8, 8'h78);
      u_host.io_read(8'hD8, rd);
      check(rd, 8'h78);
      u_host.io_read(8'hD9, rd);
      check(rd, 8'h00);
      u_host.io_write(8'hDC, 8'h0C);
      u_host.io_write(8'hDD, 8'hFF);
      u_host.io_write(8'hDC, 8'h0D);
      u_host.io_write(8'hDD, 8'hA0);
      check({2'h0, display_start[13:8]}, 8'h3F);
      check(display_start[7:0], 8'hA0);
      u_host.io_write(8'hDC, 8'h0C);
      u_host.io_read(8'hDD, rd);
      check(rd, 8'h3F);
      u_host.io_write(8'hDC, 8'h12);
      u_host.io_read(8'hDD, rd);
      check(rd, 8'h00);
      u_host.io_write(8'hDA, 8'hFA);
      check(mirror_latch_q, 8'hFA);
    end
  endtask
  task t_mem;
    begin
      mem_chk(8'h68, {8'h0E, 16'h68C0}, 1'b1, 3'h3, 3'h0);
      mem_chk(8'h08, {8'h0D, 16'h0001}, 1'b1, 3'h7, 3'h0);
      mem_chk(8'h78, {8'h0C, 16'h0002}, 1'b1, 3'h4, 3'h0);
      mem_chk(8'h38, {8'h0D, 16'hFFFF}, 1'b1, 3'h5, 3'h0);
      mem_chk(8'h08, {8'h0E, 16'h0003}, 1'b0, 3'h0, 3'h2);
      mem_chk(8'h88, {8'h0E, 16'h0004}, 1'b1, 3'h0, 3'h0);
      mem_chk(8'h88, {8'h0C, 16'h0005}, 1'b0, 3'h0, 3'h0);
    end
  endtask
  task t_pix;
    begin
      pix_chk(8'h08, 3'h5, 3'h2);
      pix_chk(8'h0A, 3'h5, 3'h0);
      pix_chk(8'h0F, 3'h0, 3'h0);
      for (i = 0; i < 8; i = i + 1) begin
        e = {5'h0, ~i[0], ~i[1], ~i[2]};
        pix_chk(i[7:0], e[2:0], e[2:0]);
      end
    end
  endtask
  // Clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Hang limit
  always @(posedge clock) begin
    cyc = cyc + 1;
    if (cyc == 4000) begin
      err_total = err_total + 1;
      end_sim;
    end
  end
  // Main sequence
  initial begin
    {rst_n, mem_rd, mem_wr, byte_load, mem_addr} = 0;
    {err_total, comparisons, cyc} = 0;
    repeat (20) @(negedge clock);
    rst_n = 1'b1;
    t_regs;
    t_mem;
    t_pix;
    end_sim;
  end
endmodule
